// ==== dmsd_map.svh ====
// Offsets, field positions, reset values and timing counts of the drive mode link
`ifndef DMSD_MAP_SVH
`define DMSD_MAP_SVH
`define DMSD_MODE_CST 8'h0A
`define DMSD_MODE_STEP 8'hFF
`define DMSD_MODE_SETUP 8'hFE
`define DMSD_IDX_MS 8'hFD
`define DMSD_CW_START 4
`define DMSD_SW_SYNC 8
`define DMSD_SW_INDEX 10
`define DMSD_SW_TARGET 12
`define DMSD_SW_FERR 13
`define DMSD_RST_NUM 16'h0080
`define DMSD_RST_DEN 16'h0001
`define DMSD_RST_PERIOD 8'h01
`define DMSD_RST_FE_WIN 16'h0100
`define DMSD_RST_FE_TMO 16'h000A
`define DMSD_CLK_MHZ 100
`define DMSD_TBASE_NS 1000000
`define DMSD_PULSE_HI_NS 200
`define DMSD_PULSE_PER_NS 1000
`define DMSD_SETTLE_NS 35000
`define DMSD_CYC_PER_MS (`DMSD_TBASE_NS * `DMSD_CLK_MHZ / 1000)
`define DMSD_HI_CYC ((`DMSD_PULSE_HI_NS * `DMSD_CLK_MHZ + 999) / 1000)
`define DMSD_PER_CYC ((`DMSD_PULSE_PER_NS * `DMSD_CLK_MHZ + 999) / 1000)
`define DMSD_SETTLE_CYC ((`DMSD_SETTLE_NS * `DMSD_CLK_MHZ + 999) / 1000)
`define DMSD_A_MODE 8'h00
`define DMSD_A_CWORD 8'h04
`define DMSD_A_TORQUE 8'h08
`define DMSD_A_SCALE 8'h0C
`define DMSD_A_INTERP 8'h10
`define DMSD_A_FOLLOW 8'h14
`define DMSD_A_STEP 8'h18
`define DMSD_A_STATUS 8'h1C
`define DMSD_A_POS 8'h20
`define DMSD_F_SUBTYPE 8
`define DMSD_F_CLREQ 9
`define DMSD_F_DIR 16
`endif

// ==== dmsd_pkg.sv ====
// Types of the drive mode link: pulse generator states for the controller end, setup states for the drive end
`default_nettype none
package dmsd_pkg;
  typedef enum logic [1:0] {
    DMSD_PG_IDLE = 2'b00,
    DMSD_PG_SETTLE = 2'b01,
    DMSD_PG_HIGH = 2'b11,
    DMSD_PG_LOW = 2'b10
  } dmsd_pg_t;
  typedef enum logic [1:0] {
    DMSD_SU_IDLE = 2'b00,
    DMSD_SU_RUN = 2'b01,
    DMSD_SU_DONE = 2'b11
  } dmsd_su_t;
endpackage
`default_nettype wire

// ==== dmsd_if.sv ====
// Link between the positioning controller and the drive
`timescale 1ns/1ps
`default_nettype none
interface dmsd_if;
  logic [7:0] mode;
  logic subtype;
  logic cl_req;
  logic [15:0] ctrl_word;
  logic [15:0] target_torque;
  logic [15:0] max_torque;
  logic setpoint_strobe;
  logic [15:0] step_num;
  logic [15:0] step_den;
  logic [7:0] interp_period;
  logic [7:0] interp_index;
  logic [15:0] fe_window;
  logic [15:0] fe_timeout;
  logic pulse_a;
  logic pulse_b;
  logic [15:0] status_word;
  logic [31:0] position;
  modport host_mp (
    output mode, subtype, cl_req, ctrl_word, target_torque, max_torque, setpoint_strobe,
    output step_num, step_den, interp_period, interp_index, fe_window, fe_timeout,
    output pulse_a, pulse_b,
    input status_word, position
  );
  modport dev_mp (
    input mode, subtype, cl_req, ctrl_word, target_torque, max_torque, setpoint_strobe,
    input step_num, step_den, interp_period, interp_index, fe_window, fe_timeout,
    input pulse_a, pulse_b,
    output status_word, position
  );
endinterface
`default_nettype wire

// ==== dmsd_sync.sv ====
// Two-stage synchroniser for the drive's pin inputs
`timescale 1ns/1ps
`default_nettype none
module dmsd_sync (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [4:0] d,
  output logic [4:0] q
);
  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 5'h00;
      sync_reg <= 5'h00;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end
  assign q = sync_reg;
endmodule // dmsd_sync
`default_nettype wire

// ==== dmsd_dev.sv ====
// Drive end: cyclic torque, step/direction and auto setup mode logic
`timescale 1ns/1ps
`default_nettype none
`include "dmsd_map.svh"
//
// Contract
// (R01) Mode value 10 selects cyclic torque
// (R02) Torque presets applied only under closed loop
// (R03) Status bit 8 shows fieldbus sync
// (R04) Torque mode bit 12 shows preset used
// (R05) Control word ignored in torque mode
// (R06) Controller sends fresh torque each cycle
// (R07) Cycle is period times 1 ms
// (R08) New set value every interpolation period
// (R09) Limit switches stay active in these modes
// (R10) Mode value FFh selects step/direction
// (R11) Each pulse moves one step width
// (R12) Pulses at most 1 MHz, 200 ns high
// (R13) Step width is numerator over denominator
// (R14) Wait 35 us after direction change
// (R15) Bit 13 flags lasting following error
// (R16) Subtype 0: pulse plus direction
// (R17) Subtype 1: pulse input selects direction
// (R18) Mode value FEh selects auto setup
// (R19) Control bit 4 rising edge starts setup
// (R20) Bit 10 shows encoder index found
// (R21) Bit 12 shows setup complete
// (R22) Closed loop only after completed setup
// (R23) Step widths accumulate into signed position
module dmsd_dev #(
  parameter int unsigned CYC_PER_MS = `DMSD_CYC_PER_MS
) (
  input wire logic clock,
  input wire logic arst_n,
  dmsd_if.dev_mp link,
  input wire logic index_pin,
  input wire logic lim_neg_pin,
  input wire logic lim_pos_pin,
  input wire logic setup_done,
  input wire logic [31:0] actual_pos,
  output logic closed_loop_on,
  output logic torque_apply,
  output logic [15:0] torque_cmd,
  output logic setup_start,
  output logic setup_busy,
  output logic [31:0] cmd_pos,
  output logic motion_inhibit
);
  logic [4:0] pins_s;
  logic [2:0] prev_reg;
  logic [31:0] ms_cnt_reg;
  logic ms_tick_reg;
  logic [8:0] gap_reg;
  logic sync_reg;
  logic cw_start_reg;
  dmsd_pkg::dmsd_su_t su_reg;
  logic start_reg, busy_reg;
  logic index_seen_reg;
  logic cl_reg;
  logic apply_reg;
  logic [15:0] torque_reg;
  logic [31:0] pos_reg;
  logic [15:0] rem_reg;
  logic [15:0] fe_ms_reg;
  logic fe_reg;
  logic [15:0] status_reg;
  logic inhibit_reg;
  logic is_cst, is_step, is_setup, idx_ok, start_edge, apply_next;
  logic index_rise, step_ev, step_fwd;
  logic [16:0] sum, quo, rem_next;
  logic [15:0] den_eff;
  logic [31:0] err, err_mag;
  logic [15:0] status_next;

  dmsd_sync dmsd_sync_i (
    .clock(clock),
    .arst_n(arst_n),
    .d({lim_pos_pin, lim_neg_pin, index_pin, link.pulse_b, link.pulse_a}),
    .q(pins_s)
  );

  assign is_cst = (link.mode == `DMSD_MODE_CST); // R01
  assign is_step = (link.mode == `DMSD_MODE_STEP); // R10
  assign is_setup = (link.mode == `DMSD_MODE_SETUP); // R18
  // Only the millisecond base is supported; any other index leaves the link unsynced
  assign idx_ok = (link.interp_index == `DMSD_IDX_MS) && (link.interp_period != 8'h00); // R07
  // Bit 4 is looked at in auto setup only, so torque mode never reacts to it
  assign start_edge = is_setup && link.ctrl_word[`DMSD_CW_START] && !cw_start_reg; // R19 R05
  assign index_rise = pins_s[2] && !prev_reg[2];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_reg <= 3'h0;
      cw_start_reg <= 1'b0;
    end else begin
      prev_reg <= pins_s[2:0];
      cw_start_reg <= link.ctrl_word[`DMSD_CW_START];
    end
  end

  // Millisecond time base for the cycle check and the following error timeout
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ms_cnt_reg <= 32'h0000_0000;
      ms_tick_reg <= 1'b0;
    end else if (ms_cnt_reg == 32'(CYC_PER_MS - 1)) begin
      ms_cnt_reg <= 32'h0000_0000;
      ms_tick_reg <= 1'b1;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h0000_0001;
      ms_tick_reg <= 1'b0;
    end
  end

  // A tick that coincides with a strobe is dropped, hence the one tick tolerance
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      gap_reg <= 9'h000;
      sync_reg <= 1'b0;
    end else begin
      if (link.setpoint_strobe) begin
        gap_reg <= 9'h000;
      end else if (ms_tick_reg && gap_reg != 9'h1FF) begin
        gap_reg <= gap_reg + 9'h001;
      end
      if (link.setpoint_strobe) begin
        sync_reg <= idx_ok && (gap_reg == {1'b0, link.interp_period} ||
                    gap_reg == {1'b0, link.interp_period} - 9'h001); // R03 R07
      end else if (!idx_ok || gap_reg > {1'b0, link.interp_period}) begin
        sync_reg <= 1'b0; // R03
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      su_reg <= dmsd_pkg::DMSD_SU_IDLE;
      start_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      start_reg <= start_edge;
      busy_reg <= (su_reg == dmsd_pkg::DMSD_SU_RUN) ? !setup_done :
                  start_edge && (su_reg == dmsd_pkg::DMSD_SU_IDLE ||
                  su_reg == dmsd_pkg::DMSD_SU_DONE);
      case (su_reg)
        dmsd_pkg::DMSD_SU_IDLE: begin
          if (start_edge) su_reg <= dmsd_pkg::DMSD_SU_RUN; // R19
        end
        dmsd_pkg::DMSD_SU_RUN: begin
          if (setup_done) su_reg <= dmsd_pkg::DMSD_SU_DONE;
        end
        dmsd_pkg::DMSD_SU_DONE: begin
          if (start_edge) su_reg <= dmsd_pkg::DMSD_SU_RUN; // R19
        end
        default: su_reg <= dmsd_pkg::DMSD_SU_IDLE;
      endcase
    end
  end

  // Index found during a run wins over the clear of a new start
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      index_seen_reg <= 1'b0;
    end else if (su_reg == dmsd_pkg::DMSD_SU_RUN && index_rise) begin
      index_seen_reg <= 1'b1; // R20
    end else if (start_edge) begin
      index_seen_reg <= 1'b0;
    end
  end

  assign apply_next = is_cst && cl_reg && sync_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cl_reg <= 1'b0;
      apply_reg <= 1'b0;
      torque_reg <= 16'h0000;
    end else begin
      cl_reg <= link.cl_req && (su_reg == dmsd_pkg::DMSD_SU_DONE); // R22
      apply_reg <= apply_next; // R02 R04
      if (!apply_next) begin
        torque_reg <= 16'h0000; // R02
      end else if (link.setpoint_strobe) begin
        torque_reg <= link.target_torque; // R01
      end
    end
  end

  // Moves toward an active limit switch are dropped
  always_comb begin
    step_ev = 1'b0;
    step_fwd = 1'b0;
    if (is_step) begin
      if (!link.subtype) begin
        step_ev = pins_s[0] && !prev_reg[0]; // R16
        step_fwd = pins_s[1]; // R16
      end else begin
        step_ev = (pins_s[0] && !prev_reg[0]) ^ (pins_s[1] && !prev_reg[1]); // R17
        step_fwd = pins_s[0] && !prev_reg[0]; // R17
      end
      if ((step_fwd && pins_s[4]) || (!step_fwd && pins_s[3])) step_ev = 1'b0; // R09
    end
  end

  // Remainder keeps the fraction so that uneven ratios do not drift
  assign den_eff = (link.step_den == 16'h0000) ? 16'h0001 : link.step_den;
  assign sum = {1'b0, rem_reg} + {1'b0, link.step_num}; // R13
  assign quo = sum / {1'b0, den_eff}; // R13
  assign rem_next = sum % {1'b0, den_eff};

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pos_reg <= 32'h0000_0000;
      rem_reg <= 16'h0000;
    end else if (step_ev) begin
      pos_reg <= step_fwd ? pos_reg + {15'h0000, quo} : pos_reg - {15'h0000, quo}; // R11 R23
      rem_reg <= rem_next[15:0];
    end
  end

  assign err = pos_reg - actual_pos;
  assign err_mag = err[31] ? (32'h0000_0000 - err) : err;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fe_ms_reg <= 16'h0000;
      fe_reg <= 1'b0;
    end else if (!(is_step && cl_reg) || err_mag <= {16'h0000, link.fe_window}) begin
      fe_ms_reg <= 16'h0000;
      fe_reg <= 1'b0;
    end else begin
      if (ms_tick_reg && fe_ms_reg != 16'hFFFF) fe_ms_reg <= fe_ms_reg + 16'h0001;
      fe_reg <= (fe_ms_reg > link.fe_timeout); // R15
    end
  end

  always_comb begin
    status_next = 16'h0000;
    if (is_cst) begin
      status_next[`DMSD_SW_SYNC] = sync_reg; // R03
      status_next[`DMSD_SW_TARGET] = apply_reg; // R04
    end else if (is_step) begin
      status_next[`DMSD_SW_FERR] = fe_reg; // R15
    end else if (is_setup) begin
      status_next[`DMSD_SW_INDEX] = index_seen_reg; // R20
      status_next[`DMSD_SW_TARGET] = (su_reg == dmsd_pkg::DMSD_SU_DONE); // R21
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= 16'h0000;
      inhibit_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      inhibit_reg <= (is_cst || is_step || is_setup) && (pins_s[3] || pins_s[4]); // R09
    end
  end

  assign link.status_word = status_reg;
  assign link.position = pos_reg;
  assign closed_loop_on = cl_reg;
  assign torque_apply = apply_reg;
  assign torque_cmd = torque_reg;
  assign setup_start = start_reg;
  assign setup_busy = busy_reg;
  assign cmd_pos = pos_reg;
  assign motion_inhibit = inhibit_reg;
endmodule // dmsd_dev
`default_nettype wire

// ==== dmsd_host.sv ====
// Controller end: APB register file, cyclic set values and step pulse generator
`timescale 1ns/1ps
`default_nettype none
`include "dmsd_map.svh"
module dmsd_host #(
  parameter int unsigned CYC_PER_MS = `DMSD_CYC_PER_MS
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  dmsd_if.host_mp link
);
  logic [31:0] mode_reg, cword_reg, torque_reg, scale_reg, interp_reg, follow_reg;
  logic [31:0] prdata_reg, rd_mux;
  logic pready_reg, pslverr_reg, hit;
  logic [31:0] ms_cnt_reg;
  logic [7:0] cyc_reg;
  logic strobe_reg;
  dmsd_pkg::dmsd_pg_t pg_reg;
  logic [11:0] tmr_reg;
  logic [15:0] left_reg;
  logic dir_reg, pa_reg, pb_reg, wr, go;

  assign wr = psel && penable && pwrite && pready_reg;
  assign go = wr && paddr == `DMSD_A_STEP && pg_reg == dmsd_pkg::DMSD_PG_IDLE &&
              pwdata[15:0] != 16'h0000;

  always_comb begin
    rd_mux = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      `DMSD_A_MODE: rd_mux = mode_reg;
      `DMSD_A_CWORD: rd_mux = cword_reg;
      `DMSD_A_TORQUE: rd_mux = torque_reg;
      `DMSD_A_SCALE: rd_mux = scale_reg;
      `DMSD_A_INTERP: rd_mux = interp_reg;
      `DMSD_A_FOLLOW: rd_mux = follow_reg;
      `DMSD_A_STEP: rd_mux = {15'h0000, pg_reg != dmsd_pkg::DMSD_PG_IDLE, left_reg};
      `DMSD_A_STATUS: rd_mux = {16'h0000, link.status_word};
      `DMSD_A_POS: rd_mux = link.position;
      default: hit = 1'b0;
    endcase
  end

  // Zero wait states: read data and error are fixed in the setup cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
      if (psel && !penable) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_reg <= !hit;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= 32'h0000_0000;
      cword_reg <= 32'h0000_0000;
      torque_reg <= 32'h0000_0000;
      scale_reg <= {`DMSD_RST_DEN, `DMSD_RST_NUM};
      interp_reg <= {16'h0000, `DMSD_IDX_MS, `DMSD_RST_PERIOD};
      follow_reg <= {`DMSD_RST_FE_TMO, `DMSD_RST_FE_WIN};
    end else if (wr) begin
      case (paddr)
        `DMSD_A_MODE: mode_reg <= {22'h00_0000, pwdata[9:0]};
        `DMSD_A_CWORD: cword_reg <= {16'h0000, pwdata[15:0]};
        `DMSD_A_TORQUE: torque_reg <= pwdata;
        `DMSD_A_SCALE: scale_reg <= pwdata;
        `DMSD_A_INTERP: interp_reg <= {16'h0000, pwdata[15:0]};
        `DMSD_A_FOLLOW: follow_reg <= pwdata;
        default: ;
      endcase
    end
  end

  // One strobe per interpolation period while torque mode is selected
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ms_cnt_reg <= 32'h0000_0000;
      cyc_reg <= 8'h00;
      strobe_reg <= 1'b0;
    end else begin
      strobe_reg <= 1'b0;
      if (ms_cnt_reg == 32'(CYC_PER_MS - 1)) begin
        ms_cnt_reg <= 32'h0000_0000;
        if (cyc_reg + 8'h01 >= interp_reg[7:0]) begin
          cyc_reg <= 8'h00;
          strobe_reg <= (mode_reg[7:0] == `DMSD_MODE_CST); // R06 R08
        end else begin
          cyc_reg <= cyc_reg + 8'h01;
        end
      end else begin
        ms_cnt_reg <= ms_cnt_reg + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pg_reg <= dmsd_pkg::DMSD_PG_IDLE;
      tmr_reg <= 12'h000;
      left_reg <= 16'h0000;
      dir_reg <= 1'b0;
      pa_reg <= 1'b0;
      pb_reg <= 1'b0;
    end else begin
      case (pg_reg)
        dmsd_pkg::DMSD_PG_IDLE: begin
          if (go) begin
            left_reg <= pwdata[15:0];
            dir_reg <= pwdata[`DMSD_F_DIR];
            if (!mode_reg[`DMSD_F_SUBTYPE]) pb_reg <= pwdata[`DMSD_F_DIR];
            if (pwdata[`DMSD_F_DIR] != dir_reg) begin
              pg_reg <= dmsd_pkg::DMSD_PG_SETTLE;
              tmr_reg <= 12'(`DMSD_SETTLE_CYC - 1); // R14
            end else begin
              pg_reg <= dmsd_pkg::DMSD_PG_HIGH;
              tmr_reg <= 12'(`DMSD_HI_CYC - 1); // R12
            end
          end
        end
        dmsd_pkg::DMSD_PG_SETTLE: begin
          if (tmr_reg == 12'h000) begin
            pg_reg <= dmsd_pkg::DMSD_PG_HIGH;
            tmr_reg <= 12'(`DMSD_HI_CYC - 1); // R12
          end else begin
            tmr_reg <= tmr_reg - 12'h001;
          end
        end
        dmsd_pkg::DMSD_PG_HIGH: begin
          if (tmr_reg == 12'h000) begin
            pg_reg <= dmsd_pkg::DMSD_PG_LOW;
            tmr_reg <= 12'(`DMSD_PER_CYC - `DMSD_HI_CYC - 1); // R12
            left_reg <= left_reg - 16'h0001;
          end else begin
            tmr_reg <= tmr_reg - 12'h001;
          end
        end
        dmsd_pkg::DMSD_PG_LOW: begin
          if (tmr_reg != 12'h000) begin
            tmr_reg <= tmr_reg - 12'h001;
          end else if (left_reg == 16'h0000) begin
            pg_reg <= dmsd_pkg::DMSD_PG_IDLE;
          end else begin
            pg_reg <= dmsd_pkg::DMSD_PG_HIGH;
            tmr_reg <= 12'(`DMSD_HI_CYC - 1);
          end
        end
        default: pg_reg <= dmsd_pkg::DMSD_PG_IDLE;
      endcase
      // Pulse lines follow the state of the previous cycle
      if (!mode_reg[`DMSD_F_SUBTYPE]) begin
        pa_reg <= (pg_reg == dmsd_pkg::DMSD_PG_HIGH); // R16
      end else begin
        pa_reg <= (pg_reg == dmsd_pkg::DMSD_PG_HIGH) && dir_reg; // R17
        pb_reg <= (pg_reg == dmsd_pkg::DMSD_PG_HIGH) && !dir_reg; // R17
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign link.mode = mode_reg[7:0];
  assign link.subtype = mode_reg[`DMSD_F_SUBTYPE];
  assign link.cl_req = mode_reg[`DMSD_F_CLREQ];
  assign link.ctrl_word = cword_reg[15:0];
  assign link.target_torque = torque_reg[15:0];
  assign link.max_torque = torque_reg[31:16];
  assign link.setpoint_strobe = strobe_reg;
  assign link.step_num = scale_reg[15:0];
  assign link.step_den = scale_reg[31:16];
  assign link.interp_period = interp_reg[7:0];
  assign link.interp_index = interp_reg[15:8];
  assign link.fe_window = follow_reg[15:0];
  assign link.fe_timeout = follow_reg[31:16];
  assign link.pulse_a = pa_reg;
  assign link.pulse_b = pb_reg;
endmodule // dmsd_host
`default_nettype wire

// ==== dmsd_properties.sv ====
// Concurrent checks on the signals of the drive mode link
`timescale 1ns/1ps
`default_nettype none
`include "dmsd_map.svh"
module dmsd_properties (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] mode,
  input wire logic subtype,
  input wire logic cl_req,
  input wire logic setpoint_strobe,
  input wire logic pulse_a,
  input wire logic pulse_b,
  input wire logic [15:0] status_word,
  input wire logic [31:0] position
);
  int settle_cnt;
  // Starts saturated so a first pulse without a direction change is legal
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      settle_cnt <= 100000;
    end else if ($changed(pulse_b)) begin
      settle_cnt <= 0;
    end else if (settle_cnt < 100000) begin
      settle_cnt <= settle_cnt + 1;
    end
  end
  int hi_cnt;
  int lo_cnt;
  // Widths are counted because the full cycle figures are too long to unroll
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hi_cnt <= 0;
      lo_cnt <= 100000;
    end else if (pulse_a) begin
      hi_cnt <= hi_cnt + 1;
      lo_cnt <= 0;
    end else begin
      hi_cnt <= 0;
      if (lo_cnt < 100000) lo_cnt <= lo_cnt + 1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_pulse_high_width: assert property ($fell(pulse_a) |-> hi_cnt >= `DMSD_HI_CYC)
    else $error("step pulse high time too short");
  a_pulse_low_gap: assert property ($rose(pulse_a) |->
    lo_cnt >= `DMSD_PER_CYC - `DMSD_HI_CYC) else $error("step pulses too close");
  a_dir_held_pulse: assert property (!subtype && pulse_a |-> $stable(pulse_b))
    else $error("direction moved during a pulse");
  a_dir_settle_time: assert property (!subtype && $rose(pulse_a) |->
    settle_cnt >= `DMSD_SETTLE_CYC) else $error("pulse too soon after direction change");
  a_strobe_torque_only: assert property (setpoint_strobe |->
    mode == `DMSD_MODE_CST || $past(mode) == `DMSD_MODE_CST) else $error("strobe outside torque");
  a_sync_after_strobe: assert property ($rose(status_word[`DMSD_SW_SYNC]) |->
    $past(setpoint_strobe, 2) || $past(setpoint_strobe, 3)) else $error("sync without strobe");
  a_torque_needs_loop: assert property (status_word[`DMSD_SW_TARGET] && mode == `DMSD_MODE_CST
    && $past(mode, 5) == `DMSD_MODE_CST |-> $past(cl_req, 3) || $past(cl_req, 4)
    || $past(cl_req, 5)) else $error("torque followed without closed loop");
  a_ferr_step_loop: assert property ($rose(status_word[`DMSD_SW_FERR]) |->
    $past(mode) == `DMSD_MODE_STEP && $past(cl_req, 3)) else $error("following error out of mode");
  a_pos_from_pulse: assert property ($changed(position) |->
    $past(pulse_a, 3) || (subtype && $past(pulse_b, 3)))
    else $error("position moved without a pulse");
  c_sync: cover property ($rose(status_word[`DMSD_SW_SYNC]));
  c_ferr: cover property ($rose(status_word[`DMSD_SW_FERR]));
  c_dual: cover property (subtype && $rose(pulse_a));
endmodule // dmsd_properties
`default_nettype wire

// ==== drive_mode_step_dir_control_tb.sv ====
// Self-checking bench: host and drive ends joined by the link
`timescale 1ns/1ps
`default_nettype none
`include "dmsd_map.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module drive_mode_step_dir_control_tb;
  localparam int unsigned CPM = 50;
  logic clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, cmd_pos, actual_pos = 0;
  logic index_pin = 0, lim_neg_pin = 0, lim_pos_pin = 0, setup_done = 0;
  logic closed_loop_on, torque_apply, setup_start, setup_busy, motion_inhibit;
  logic [15:0] torque_cmd;
  int failures = 0, check_count = 0, cycles = 0, starts = 0;
  always #5 clock = ~clock;
  dmsd_if lnk ();
  dmsd_host #(.CYC_PER_MS(CPM)) dmsd_host_i (.clock(clock), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(lnk));
  dmsd_dev #(.CYC_PER_MS(CPM)) dmsd_dev_i (.clock(clock), .arst_n(arst_n), .link(lnk),
    .index_pin(index_pin), .lim_neg_pin(lim_neg_pin), .lim_pos_pin(lim_pos_pin),
    .setup_done(setup_done), .actual_pos(actual_pos), .closed_loop_on(closed_loop_on),
    .torque_apply(torque_apply), .torque_cmd(torque_cmd), .setup_start(setup_start),
    .setup_busy(setup_busy), .cmd_pos(cmd_pos), .motion_inhibit(motion_inhibit));
  dmsd_properties dmsd_properties_i (.clock(clock), .arst_n(arst_n), .mode(lnk.mode),
    .subtype(lnk.subtype), .cl_req(lnk.cl_req), .setpoint_strobe(lnk.setpoint_strobe),
    .pulse_a(lnk.pulse_a), .pulse_b(lnk.pulse_b), .status_word(lnk.status_word),
    .position(lnk.position));
  // Entered just after a rising edge; returns one edge after release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock); penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clock);
  endtask
  task automatic step(input logic [31:0] d, input logic [31:0] exp_pos);
    apb(1, `DMSD_A_STEP, d);
    do apb(0, `DMSD_A_STEP, 32'h0000_0000); while (rd[16] !== 1'b0);
    repeat (8) @(posedge clock);
    `CHK(lnk.position, exp_pos)
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (setup_start === 1'b1) starts++;
    if (cycles == 40000) begin
      failures++;
      $display("unexpected at %0t: run took too long", $time);
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    arst_n <= 1;
    repeat (2) @(posedge clock);
    `CHK({lnk.step_num, lnk.step_den}, 32'h0080_0001)
    `CHK(lnk.interp_index, `DMSD_IDX_MS)
    apb(0, 8'h40, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    apb(1, `DMSD_A_MODE, 32'h0000_02FE);
    apb(1, `DMSD_A_CWORD, 32'h0000_0010);
    repeat (4) @(posedge clock);
    `CHK({setup_busy, closed_loop_on}, 2'b10)
    index_pin <= 1;
    repeat (8) @(posedge clock);
    apb(0, `DMSD_A_STATUS, 32'h0000_0000);
    `CHK({rd[`DMSD_SW_INDEX], rd[`DMSD_SW_TARGET]}, 2'b10)
    index_pin <= 0;
    setup_done <= 1;
    @(posedge clock) setup_done <= 0;
    repeat (4) @(posedge clock);
    `CHK({setup_busy, closed_loop_on}, 2'b01)
    apb(1, `DMSD_A_CWORD, 32'h0000_0010);
    apb(0, `DMSD_A_STATUS, 32'h0000_0000);
    `CHK({setup_busy, rd[`DMSD_SW_TARGET]}, 2'b01)
    apb(1, `DMSD_A_CWORD, 32'h0000_0000);
    apb(1, `DMSD_A_CWORD, 32'h0000_0010);
    repeat (4) @(posedge clock);
    apb(0, `DMSD_A_STATUS, 32'h0000_0000);
    `CHK({setup_busy, rd[`DMSD_SW_INDEX]}, 2'b10)
    setup_done <= 1;
    @(posedge clock) setup_done <= 0;
    apb(1, `DMSD_A_TORQUE, 32'h4000_1234);
    apb(1, `DMSD_A_MODE, 32'h0000_020A);
    repeat (4 * CPM) @(posedge clock);
    apb(0, `DMSD_A_STATUS, 32'h0000_0000);
    `CHK({rd[`DMSD_SW_TARGET], rd[`DMSD_SW_SYNC]}, 2'b11)
    `CHK(torque_cmd, 16'h1234)
    apb(1, `DMSD_A_CWORD, 32'h0000_0000);
    apb(1, `DMSD_A_CWORD, 32'h0000_0010);
    repeat (2 * CPM) @(posedge clock);
    `CHK({torque_apply, setup_busy}, 2'b10)
    apb(1, `DMSD_A_MODE, 32'h0000_000A);
    repeat (8) @(posedge clock);
    `CHK({torque_apply, torque_cmd}, 17'h0_0000)
    apb(1, `DMSD_A_INTERP, 32'h0000_0001);
    repeat (3 * CPM) @(posedge clock);
    apb(0, `DMSD_A_STATUS, 32'h0000_0000);
    `CHK(rd[`DMSD_SW_SYNC], 1'b0)
    apb(1, `DMSD_A_INTERP, 32'h0000_FD01);
    apb(1, `DMSD_A_MODE, 32'h0000_02FF);
    step(32'h0001_0003, 32'h0000_0180);
    apb(0, `DMSD_A_STATUS, 32'h0000_0000);
    `CHK(rd[`DMSD_SW_FERR], 1'b0)
    repeat (14 * CPM) @(posedge clock);
    apb(0, `DMSD_A_STATUS, 32'h0000_0000);
    `CHK(rd[`DMSD_SW_FERR], 1'b1)
    // Track the command so later moves do not raise a following error
    actual_pos <= 32'hFFFF_FF80;
    apb(1, `DMSD_A_SCALE, 32'h0002_0200);
    step(32'h0000_0002, 32'hFFFF_FF80);
    apb(1, `DMSD_A_MODE, 32'h0000_03FF);
    step(32'h0001_0001, 32'h0000_0080);
    apb(0, `DMSD_A_POS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0080)
    lim_pos_pin <= 1;
    step(32'h0001_0001, 32'h0000_0080);
    `CHK({motion_inhibit, cmd_pos}, {1'b1, 32'h0000_0080})
    `CHK(starts, 2)
    tally_and_finish();
  end
endmodule // drive_mode_step_dir_control_tb
`default_nettype wire
